// File: verilog/mpd_device.sv
// Modem pump device end: host register port, serial data port, relay and scope outputs
// Contract
// RULE1 - Eight-line bidirectional host data bus, bit7 MSB
// RULE2 - Respond only while bus select low
// RULE3 - Write strobe low captures bus data
// RULE4 - Read strobe low drives selected register
// RULE5 - Select lines form register address, top MSB
// RULE6 - Interrupt open-drain, pulls low only
// RULE7 - Interrupt only from enabled rx/tx sources
// RULE8 - Reset low forces whole reset state
// RULE9 - Carrier detect low while signal detected
// RULE10 - Receive data shifted out serially
// RULE11 - Transmit bit clock 2400/1200/300 Hz
// RULE12 - Serial transmit input used when parallel bit clear
// RULE13 - Off-hook output low energises relay
// RULE14 - Send pin OR request bit selects transmit
// RULE15 - Standby ignores send request pin
// RULE16 - Scope data stable at scope clock rise
// RULE17 - Scope word: eight X bits, eight Y
// RULE18 - Strobe pulses after each completed word
// RULE19 - Receive bit clock follows data rate
// RULE20 - Eight direct registers, indirect RAM access; no RAM is modelled, the RAM control register is storage whose bit 4 selects parallel transmit
// RULE21 - Data bus floats unless selected read
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module mpd_device
   import mpd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   mpd_if.dev pins,
   input wire logic rx_line_bit,
   input wire logic line_signal_present,
   input wire logic send_request_n,
   input wire logic tx_serial_in,
   input wire logic [7:0] scope_x_byte,
   input wire logic [7:0] scope_y_byte,
   output logic rx_serial_out,
   output logic tx_bit_clock,
   output logic rx_bit_clock,
   output logic carrier_detect_n,
   output logic offhook_relay_n,
   output logic tx_active,
   output logic tx_line_bit,
   output logic scope_clock,
   output logic scope_serial_out,
   output logic scope_load_strobe
);
   import mpd_pkg::*;

   // ************************************************************
   // Host register port
   // ************************************************************
   logic [7:0] regs_q [8];
   logic wr_q, rd_q;
   logic [7:0] rx_byte_q, tx_byte_q;
   logic rx_flag_q, tx_flag_q;
   logic rx_done, tx_done;
   logic [2:0] addr;
   logic wr_now, rd_now, wr_edge, rd_edge;
   logic [7:0] rd_mux;
   logic send_mode;

   assign addr = pins.reg_select_lines; // see RULE5
   assign wr_now = !pins.bus_select_n && !pins.write_strobe_n; // see RULE2
   assign rd_now = !pins.bus_select_n && !pins.read_strobe_n; // see RULE2
   assign wr_edge = wr_now && !wr_q;
   assign rd_edge = rd_q && !rd_now;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= wr_now;
         rd_q <= rd_now;
      end
   end

   // Plain storage for the eight direct registers; RAM window regs hold their byte
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= RST_BYTE; // see RULE8
         end
      end else if (wr_edge) begin
         regs_q[addr] <= pins.host_data_lines; // see RULE3, RULE20
      end
   end

   // Flags: hardware set wins over a host clear by access
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_flag_q <= 1'b0;
         tx_flag_q <= 1'b0;
      end else begin
         if (rx_done) begin
            rx_flag_q <= 1'b1;
         end else if (rd_edge && addr == REG_RX_DATA) begin
            rx_flag_q <= 1'b0;
         end
         if (tx_done) begin
            tx_flag_q <= 1'b1;
         end else if (wr_edge && addr == REG_TX_DATA) begin
            tx_flag_q <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = regs_q[addr];
      unique case (addr)
         REG_RX_DATA: rd_mux = rx_byte_q;
         REG_STATUS: rd_mux = {4'h0, send_mode, !carrier_detect_n, tx_flag_q, rx_flag_q};
         REG_SCOPE_X: rd_mux = scope_x_byte;
         REG_SCOPE_Y: rd_mux = scope_y_byte;
         default: rd_mux = regs_q[addr];
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pins.host_data_dev_o <= RST_BYTE;
         pins.host_data_dev_oe_n <= 8'hFF;
      end else begin
         pins.host_data_dev_o <= rd_mux; // see RULE1, RULE4
         pins.host_data_dev_oe_n <= rd_now ? 8'h00 : 8'hFF; // see RULE21
      end
   end

   // Open-drain interrupt: only ever drives low
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pins.host_irq_o <= 1'b0;
         pins.host_irq_oe_n <= 1'b1;
      end else begin
         pins.host_irq_o <= 1'b0; // see RULE6
         pins.host_irq_oe_n <= !((rx_flag_q && regs_q[REG_HOST_CTRL][BIT_RX_IE]) ||
                                 (tx_flag_q && regs_q[REG_HOST_CTRL][BIT_TX_IE])); // see RULE7
      end
   end

   // ************************************************************
   // Mode, relay, carrier
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         offhook_relay_n <= 1'b1;
         carrier_detect_n <= 1'b1;
         tx_active <= 1'b0;
      end else begin
         offhook_relay_n <= !regs_q[REG_CONTROL][BIT_OFFHOOK]; // see RULE13
         carrier_detect_n <= !line_signal_present; // see RULE9
         tx_active <= send_mode;
      end
   end
   // Standby masks the pin but not the software bit
   assign send_mode = regs_q[REG_CONTROL][BIT_SEND_REQ] ||
                      (!send_request_n && !regs_q[REG_CONTROL][BIT_STANDBY]); // see RULE14, RULE15

   // ************************************************************
   // Bit clocks
   // ************************************************************
   logic [19:0] half_cnt_q, half_lim;
   logic bit_tick, bclk_q;
   always_comb begin
      unique case ({regs_q[REG_CONTROL][BIT_RATE_HI], regs_q[REG_CONTROL][BIT_RATE_LO]})
         2'b01: half_lim = HALF_MID;
         2'b10: half_lim = HALF_LO;
         default: half_lim = HALF_HI;
      endcase
   end
   assign bit_tick = (half_cnt_q >= half_lim - 20'h1) && bclk_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         half_cnt_q <= 20'h0;
         bclk_q <= 1'b0;
      end else if (half_cnt_q >= half_lim - 20'h1) begin
         half_cnt_q <= 20'h0;
         bclk_q <= !bclk_q; // see RULE11, RULE19
      end else begin
         half_cnt_q <= half_cnt_q + 20'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_bit_clock <= 1'b0;
         rx_bit_clock <= 1'b0;
      end else begin
         tx_bit_clock <= bclk_q; // see RULE11
         rx_bit_clock <= bclk_q; // see RULE19
      end
   end

   // ************************************************************
   // Serial data paths, one bit per bit clock, LSB first
   // ************************************************************
   logic [2:0] rx_cnt_q, tx_cnt_q;
   logic [7:0] rx_sh_q;
   assign rx_done = bit_tick && rx_cnt_q == 3'h7;
   assign tx_done = bit_tick && tx_cnt_q == 3'h7 && send_mode;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_cnt_q <= 3'h0;
         rx_sh_q <= RST_BYTE;
         rx_byte_q <= RST_BYTE;
         rx_serial_out <= 1'b1;
      end else if (bit_tick) begin
         rx_cnt_q <= rx_cnt_q + 3'h1;
         rx_sh_q <= {rx_line_bit, rx_sh_q[7:1]};
         rx_serial_out <= rx_line_bit; // see RULE10
         if (rx_cnt_q == 3'h7) begin
            rx_byte_q <= {rx_line_bit, rx_sh_q[7:1]};
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_cnt_q <= 3'h0;
         tx_byte_q <= RST_BYTE;
         tx_line_bit <= 1'b1;
      end else if (bit_tick && send_mode) begin
         tx_cnt_q <= tx_cnt_q + 3'h1;
         if (tx_cnt_q == 3'h0) begin
            tx_byte_q <= regs_q[REG_TX_DATA];
         end
         if (regs_q[REG_RAM_CTRL][BIT_TX_PAR]) begin
            tx_line_bit <= (tx_cnt_q == 3'h0) ? regs_q[REG_TX_DATA][0] : tx_byte_q[tx_cnt_q];
         end else begin
            tx_line_bit <= tx_serial_in; // see RULE12
         end
      end
   end

   // ************************************************************
   // Scope serialiser: data changes on the falling half, stable at rise
   // ************************************************************
   logic [7:0] sdiv_q;
   logic [4:0] sbit_q;
   logic [15:0] sword_q;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sdiv_q <= 8'h0;
         sbit_q <= 5'h0;
         sword_q <= 16'h0;
         scope_clock <= 1'b0;
         scope_serial_out <= 1'b0;
         scope_load_strobe <= 1'b0;
      end else begin
         scope_load_strobe <= 1'b0;
         if (sdiv_q == SCOPE_DIV - 8'h1) begin
            sdiv_q <= 8'h0;
            scope_clock <= !scope_clock;
            if (scope_clock) begin
               // Falling edge: next bit; a new word starts at once so each word takes exactly 16 clocks
               scope_serial_out <= (sbit_q == 5'(SCOPE_BITS)) ? scope_x_byte[0] : sword_q[sbit_q[3:0]]; // see RULE16
               if (sbit_q == 5'(SCOPE_BITS)) begin
                  sword_q <= {scope_y_byte, scope_x_byte}; // see RULE17
                  sbit_q <= 5'h1;
                  scope_load_strobe <= 1'b1; // see RULE18
               end else begin
                  sbit_q <= sbit_q + 5'h1;
               end
            end
         end else begin
            sdiv_q <= sdiv_q + 8'h1;
         end
      end
   end
endmodule // mpd_device

// File: verilog/mpd_pkg.sv
// Package of shared constants and types for the modem pump pin interface
package mpd_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned RATE_HI_HZ = 2400;
   localparam int unsigned RATE_MID_HZ = 1200;
   localparam int unsigned RATE_LO_HZ = 300;
   // Half-period counts of the bit clocks at the core clock rate
   localparam logic [19:0] HALF_HI = 20'(CLK_HZ / (2 * RATE_HI_HZ));
   localparam logic [19:0] HALF_MID = 20'(CLK_HZ / (2 * RATE_MID_HZ));
   localparam logic [19:0] HALF_LO = 20'(CLK_HZ / (2 * RATE_LO_HZ));
   localparam logic [7:0] SCOPE_DIV = 8'h10;
   localparam int unsigned SCOPE_BITS = 16;
   // Interface register indices on the three select lines
   localparam logic [2:0] REG_TX_DATA = 3'h0;
   localparam logic [2:0] REG_RX_DATA = 3'h1;
   localparam logic [2:0] REG_HOST_CTRL = 3'h2;
   localparam logic [2:0] REG_SCOPE_X = 3'h3;
   localparam logic [2:0] REG_CONTROL = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;
   localparam logic [2:0] REG_RAM_CTRL = 3'h6;
   localparam logic [2:0] REG_SCOPE_Y = 3'h7;
   // Field positions
   localparam int unsigned BIT_RX_IE = 0;
   localparam int unsigned BIT_TX_IE = 1;
   localparam int unsigned BIT_RX_FLAG = 0;
   localparam int unsigned BIT_TX_FLAG = 1;
   localparam int unsigned BIT_CARRIER = 2;
   localparam int unsigned BIT_TX_MODE = 3;
   localparam int unsigned BIT_OFFHOOK = 0;
   localparam int unsigned BIT_STANDBY = 2;
   localparam int unsigned BIT_SEND_REQ = 3;
   localparam int unsigned BIT_RATE_LO = 4;
   localparam int unsigned BIT_RATE_HI = 5;
   localparam int unsigned BIT_TX_PAR = 4;
   localparam int unsigned BIT_CARRIER_IN = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   typedef enum logic [1:0] {MPD_RATE_2400, MPD_RATE_1200, MPD_RATE_300} mpd_rate_t;
   // Host-side access sequencer states
   typedef enum logic [1:0] {MPD_H_IDLE, MPD_H_SETUP, MPD_H_STROBE, MPD_H_DONE} mpd_hstate_t;
   localparam logic [3:0] STROBE_CYC = 4'h4;
   // AXI4-Lite offsets of the controller's own registers
   localparam logic [3:0] AXI_CMD = 4'h0;
   localparam logic [3:0] AXI_RDATA = 4'h4;
   localparam logic [3:0] AXI_STAT = 4'h8;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// File: verilog/mpd_if.sv
// Pin-level interface joining the pump device and its host controller
`timescale 1ns/1ps
interface mpd_if;
   logic [7:0] host_data_dev_o;
   logic [7:0] host_data_dev_oe_n;
   logic [7:0] host_data_host_o;
   logic [7:0] host_data_host_oe_n;
   logic [7:0] host_data_lines;
   logic bus_select_n;
   logic write_strobe_n;
   logic read_strobe_n;
   logic [2:0] reg_select_lines;
   logic host_irq_o;
   logic host_irq_oe_n;
   logic host_irq_n;
   // Resolved wire levels: pull-up on the interrupt, host wins on a clash
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!host_data_host_oe_n[i]) begin
            host_data_lines[i] = host_data_host_o[i];
         end else if (!host_data_dev_oe_n[i]) begin
            host_data_lines[i] = host_data_dev_o[i];
         end else begin
            host_data_lines[i] = 1'b1;
         end
      end
      host_irq_n = host_irq_oe_n ? 1'b1 : host_irq_o;
   end
   modport dev (
      input host_data_lines,
      input bus_select_n,
      input write_strobe_n,
      input read_strobe_n,
      input reg_select_lines,
      output host_data_dev_o,
      output host_data_dev_oe_n,
      output host_irq_o,
      output host_irq_oe_n
   );
   modport host (
      input host_data_lines,
      input host_irq_n,
      output host_data_host_o,
      output host_data_host_oe_n,
      output bus_select_n,
      output write_strobe_n,
      output read_strobe_n,
      output reg_select_lines
   );
endinterface

// File: verilog/mpd_host.sv
// Host controller end: AXI4-Lite slave that runs byte accesses on the pump pins
`timescale 1ns/1ps
module mpd_host
   import mpd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   mpd_if.host pins,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import mpd_pkg::*;

   // ************************************************************
   // AXI write side: CMD = {go, wr, addr[10:8], data[7:0]}, bit12 must be set to start, bit11 selects write
   // ************************************************************
   logic aw_got_q, w_got_q;
   logic [3:0] aw_q;
   logic [31:0] wd_q;
   mpd_hstate_t st_q;
   logic [3:0] cnt_q;
   logic is_wr_q, busy;
   logic [7:0] rbyte_q;
   logic start;

   assign busy = st_q != MPD_H_IDLE;
   assign start = aw_got_q && w_got_q && !s_axi_bvalid && aw_q == AXI_CMD && !busy;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_q <= 4'h0;
         wd_q <= 32'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            aw_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wd_q <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         // A command while a pin access runs waits for it; others answer at once
         if (aw_got_q && w_got_q && !s_axi_bvalid && (aw_q != AXI_CMD || !busy)) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_q == AXI_CMD) ? AXI_OKAY : AXI_SLVERR;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Pin sequencer: setup, strobe held STROBE_CYC cycles, release
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= MPD_H_IDLE;
         cnt_q <= 4'h0;
         is_wr_q <= 1'b0;
         rbyte_q <= 8'h0;
         pins.bus_select_n <= 1'b1;
         pins.write_strobe_n <= 1'b1;
         pins.read_strobe_n <= 1'b1;
         pins.reg_select_lines <= 3'h0;
         pins.host_data_host_o <= 8'h0;
         pins.host_data_host_oe_n <= 8'hFF;
      end else begin
         unique case (st_q)
            MPD_H_IDLE: begin
               if (start && wd_q[12]) begin
                  is_wr_q <= wd_q[11];
                  pins.reg_select_lines <= wd_q[10:8]; // see RULE5
                  pins.bus_select_n <= 1'b0; // see RULE2
                  pins.host_data_host_o <= wd_q[7:0]; // see RULE1
                  pins.host_data_host_oe_n <= wd_q[11] ? 8'h00 : 8'hFF;
                  st_q <= MPD_H_SETUP;
               end
            end
            MPD_H_SETUP: begin
               pins.write_strobe_n <= !is_wr_q; // see RULE3
               pins.read_strobe_n <= is_wr_q; // see RULE4
               cnt_q <= 4'h0;
               st_q <= MPD_H_STROBE;
            end
            MPD_H_STROBE: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == STROBE_CYC - 4'h1) begin
                  if (!is_wr_q) begin
                     rbyte_q <= pins.host_data_lines;
                  end
                  pins.write_strobe_n <= 1'b1;
                  pins.read_strobe_n <= 1'b1;
                  st_q <= MPD_H_DONE;
               end
            end
            MPD_H_DONE: begin
               pins.bus_select_n <= 1'b1;
               pins.host_data_host_oe_n <= 8'hFF;
               st_q <= MPD_H_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // AXI read side
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= AXI_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            unique case (s_axi_araddr)
               AXI_CMD: s_axi_rdata <= 32'h0;
               AXI_RDATA: s_axi_rdata <= {24'h0, rbyte_q};
               AXI_STAT: s_axi_rdata <= {30'h0, !pins.host_irq_n, busy};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= AXI_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // mpd_host

// File: testbench/mpd_checker.sv
// Concurrent checks on the pin interface between the pump device and its host
`timescale 1ns/1ps
module mpd_checker (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] host_data_dev_oe_n,
   input wire logic [7:0] host_data_host_oe_n,
   input wire logic bus_select_n,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [2:0] reg_select_lines,
   input wire logic host_irq_o,
   input wire logic host_irq_oe_n,
   input wire logic host_irq_n
);
   // ********************************
   // Pin rules
   // ********************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_bus_whole: assert property (host_data_dev_oe_n inside {8'h00, 8'hFF})
      else $error("device drives part of the bus");
   chk_strobe_sel: assert property (!write_strobe_n || !read_strobe_n |-> !bus_select_n)
      else $error("strobe without select");
   chk_idle_quiet: assert property (bus_select_n && $past(bus_select_n) |-> host_data_dev_oe_n == 8'hFF)
      else $error("device drives while deselected");
   chk_no_clash: assert property (!(host_data_dev_oe_n == 8'h00 && host_data_host_oe_n == 8'h00))
      else $error("both ends drive the bus");
   chk_write_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
      else $error("write strobe length wrong");
   chk_read_drive: assert property ($fell(read_strobe_n) && !bus_select_n |-> ##[1:2] host_data_dev_oe_n == 8'h00)
      else $error("read not answered");
   chk_addr_hold: assert property ($fell(read_strobe_n) |-> $stable(reg_select_lines) [*4] ##1 read_strobe_n)
      else $error("address moved during read");
   chk_irq_drain: assert property (!host_irq_oe_n |-> !host_irq_o && !host_irq_n)
      else $error("interrupt drives high");
   chk_bus_float: assert property (host_data_dev_oe_n != 8'hFF |->
      (!bus_select_n && !read_strobe_n) || (!$past(bus_select_n) && !$past(read_strobe_n)))
      else $error("bus driven outside a read");
   cov_write: cover property ($fell(write_strobe_n));
   cov_read: cover property ($fell(read_strobe_n) ##2 host_data_dev_oe_n == 8'h00);
   cov_irq: cover property (!host_irq_n);
endmodule // mpd_checker

// File: testbench/modem_pump_digital_pins_tb.sv
// Bench joining both ends, driving AXI4-Lite and comparing against a register model
`timescale 1ns/1ps
module modem_pump_digital_pins_tb;
   import mpd_pkg::*;
   logic core_clk = 0, rstn = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rx_line_bit = 0, line_signal_present = 0, send_request_n = 1, tx_serial_in = 0;
   logic [7:0] scope_x_byte = 0, scope_y_byte = 0, q;
   logic rx_serial_out, tx_bit_clock, rx_bit_clock, carrier_detect_n, offhook_relay_n;
   logic tx_active, tx_line_bit, scope_clock, scope_serial_out, scope_load_strobe;
   int mismatches = 0, compares = 0, n, t;
   int regm [8];
   logic [1:0] rxh = 2'h0, txh = 2'h0;
   logic rbc = 1'b0;
   mpd_if link ();
   mpd_device i_mpd_device (.pins(link), .*);
   mpd_host i_mpd_host (.pins(link), .*);
   mpd_checker i_mpd_checker (.core_clk(core_clk), .rstn(rstn), .host_data_dev_oe_n(link.host_data_dev_oe_n),
      .host_data_host_oe_n(link.host_data_host_oe_n), .bus_select_n(link.bus_select_n),
      .write_strobe_n(link.write_strobe_n), .read_strobe_n(link.read_strobe_n),
      .reg_select_lines(link.reg_select_lines), .host_irq_o(link.host_irq_o),
      .host_irq_oe_n(link.host_irq_oe_n), .host_irq_n(link.host_irq_n));
   // ********************************
   // Tasks
   // ********************************
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Byte access on the pins through the controller; waits for busy to drop
   task automatic pin_op(input logic wr, input logic [2:0] rg, input logic [7:0] d, output logic [7:0] o);
      logic [31:0] w;
      logic [1:0] s;
      axi_wr(AXI_CMD, {19'h0, 1'b1, wr, rg, d}, s);
      do axi_rd(AXI_STAT, w, s); while (w[0] !== 1'b0);
      axi_rd(AXI_RDATA, w, s);
      o = w[7:0];
   endtask
   task automatic half_len(input bit rx, output int c);
      c = 0;
      do @(posedge core_clk); while ((rx ? rx_bit_clock : tx_bit_clock) !== 1'b0);
      do @(posedge core_clk); while ((rx ? rx_bit_clock : tx_bit_clock) !== 1'b1);
      do begin
         @(posedge core_clk);
         c++;
      end while ((rx ? rx_bit_clock : tx_bit_clock) === 1'b1);
   endtask
   // ********************************
   // Stimulus and checks
   // ********************************
   initial forever #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      rx_line_bit <= $urandom;
      tx_serial_in <= $urandom;
      rxh <= {rxh[0], rx_line_bit};
      txh <= {txh[0], tx_serial_in};
      rbc <= rx_bit_clock;
      // Bits taken at a tick show two edges later, when the bit clock is seen low
      if (rstn && rbc && !rx_bit_clock) begin
         cmp("rx data", rxh[1], rx_serial_out);
         cmp("tx data", regm[6][BIT_TX_PAR] ? RST_BYTE[0] : txh[1], tx_line_bit);
      end
   end
   // Longest test is the bit clock measurement, up to about 80k cycles
   initial begin
      #(95000 * 8);
      mismatches++;
      complete_run();
   end
   initial begin
      void'($urandom(52227));
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      cmp("relay", 1, offhook_relay_n);
      cmp("carrier", 1, carrier_detect_n);
      pin_op(0, REG_CONTROL, 0, q);
      cmp("ctl rst", RST_BYTE, q);
      axi_rd(4'hC, v, r);
      cmp("rd resp", AXI_SLVERR, r);
      axi_wr(4'hC, 0, r);
      cmp("wr resp", AXI_SLVERR, r);
      for (int i = 2; i < 8; i += 2) begin
         regm[i] = $urandom & (i == 2 ? 8'h03 : i == 4 ? 8'h1D : 8'h10);
         pin_op(1, i[2:0], regm[i][7:0], q);
      end
      for (int i = 2; i < 8; i += 2) begin
         pin_op(0, i[2:0], 0, q);
         cmp("reg", regm[i], q);
      end
      for (int i = 0; i < 4; i++) begin
         send_request_n <= !i[0];
         pin_op(1, REG_CONTROL, {4'h0, i[1], 2'b00, i[0]}, q);
         repeat (3) @(posedge core_clk);
         cmp("tx mode", i[0] | i[1], tx_active);
         cmp("relay", !i[0], offhook_relay_n);
      end
      pin_op(1, REG_CONTROL, 8'h04, q);
      for (int i = 0; i < 2; i++) begin
         send_request_n <= i[0];
         repeat (3) @(posedge core_clk);
         cmp("standby", 0, tx_active);
      end
      line_signal_present <= 1'b1;
      while (carrier_detect_n !== 1'b0) @(posedge core_clk);
      pin_op(0, REG_STATUS, 0, q);
      cmp("carrier flag", 1, q[BIT_CARRIER]);
      line_signal_present <= 1'b0;
      while (carrier_detect_n !== 1'b1) @(posedge core_clk);
      pin_op(1, REG_HOST_CTRL, 0, q);
      n = 0;
      repeat (200) begin
         @(posedge core_clk);
         if (link.host_irq_n !== 1'b1) n++;
      end
      cmp("irq quiet", 0, n);
      scope_x_byte <= $urandom;
      scope_y_byte <= $urandom;
      repeat (2) begin
         @(posedge core_clk);
         while (scope_load_strobe !== 1'b1) @(posedge core_clk);
      end
      n = 0;
      v = 0;
      t = scope_clock;
      do begin
         @(posedge core_clk);
         if (scope_clock === 1'b1 && t == 0) begin
            v = {scope_serial_out, v[31:1]};
            n++;
         end
         t = scope_clock;
      end while (scope_load_strobe !== 1'b1);
      cmp("scope bits", 16, n);
      cmp("scope word", {scope_y_byte, scope_x_byte}, v[31:16]);
      send_request_n <= 1'b0;
      pin_op(1, REG_CONTROL, 8'h00, q);
      fork
         half_len(1'b0, n);
         half_len(1'b1, t);
      join
      cmp("tx half", HALF_HI, n);
      cmp("rx half", HALF_HI, t);
      @(posedge core_clk);
      complete_run();
   end
endmodule // modem_pump_digital_pins_tb
